// [bdm_defines.svh]
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH
// Summary of operation
// RULE_01: Direct accesses use bank 0 when the bank select bit is clear, bank 1 when set.
// RULE_02: Software keeps the indirect bank bit and upper bank select bit at zero.
// RULE_03: General storage holds 128 locations of eight bits each.
// RULE_04: Every location is reachable directly or through the indirect address pointer.
// RULE_05: Special function registers are static storage needing no refresh.
// RULE_06: Offset 0x02 shows the program counter low byte, clearing to zero at reset.
// RULE_07: General storage answers at 0x20-0x7F in bank 0 and 0xA0-0xBF in bank 1.
// RULE_08: Bank 1 addresses 0xF0-0xFF reach the same storage as 0x70-0x7F.
// RULE_09: Reads of unimplemented locations return zero.
// RULE_10: Special function registers occupy the lowest 32 locations of each bank.
// RULE_11: Writes to unimplemented locations are discarded without changing state.

// ==========================================
// Core special register offsets
`define BDM_OFS_INDIRECT_DATA 5'h00
`define BDM_OFS_PC_LOW 5'h02
`define BDM_OFS_STATUS 5'h03
`define BDM_OFS_POINTER 5'h04
`define BDM_OFS_PC_HIGH_LATCH 5'h0A

// ==========================================
// Address map
`define BDM_SFR_LIMIT 7'h20
`define BDM_B0_GPR_LO 8'h20
`define BDM_B0_GPR_HI 8'h7F
`define BDM_B1_GPR_LO 8'hA0
`define BDM_B1_GPR_HI 8'hBF
`define BDM_B1_ALIAS_LO 8'hF0
`define BDM_B1_ALIAS_HI 8'hFF
`define BDM_B1_GPR_BASE_IDX 7'h60
`define BDM_ALIAS_BASE_IDX 7'h50
`define BDM_GPR_DEPTH 128

// ==========================================
// Status field positions
`define BDM_ST_INDIRECT_BANK 7
`define BDM_ST_UPPER_BANK 6
`define BDM_ST_BANK_SELECT 5
`define BDM_ST_TIMEOUT 4
`define BDM_ST_POWERDOWN 3
`define BDM_ST_WRITE_MASK 8'hE7
`define BDM_ST_FLAG_MASK 8'h07

// ==========================================
// Reset values
`define BDM_RST_PC_LOW 8'h00
`define BDM_RST_STATUS 8'h18
`define BDM_RST_POINTER 8'h00
`define BDM_RST_PC_HIGH_LATCH 5'h00
`define BDM_RST_READ 8'h00
`endif

// [bdm_pkg.sv]
package bdm_pkg;
  typedef enum logic [1:0] {
    BDM_REGION_NONE = 2'h0,
    BDM_REGION_SFR = 2'h1,
    BDM_REGION_GPR = 2'h3
  } bdm_region_type;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } bdm_req_type;

  typedef struct packed {
    bdm_region_type region;
    logic [6:0] gpr_index;
    logic [4:0] sfr_offset;
  } bdm_decode_type;
endpackage

// [bdm_addr_decoder.sv]
`timescale 1ns/1ps
`include "bdm_defines.svh"
module bdm_addr_decoder
  import bdm_pkg::*;
(
  input wire logic [7:0] full_addr,
  output bdm_decode_type dec
);
  // ==========================================
  // Region decode
  always_comb
  begin
    dec.region = BDM_REGION_NONE;
    dec.gpr_index = 7'h00;
    dec.sfr_offset = full_addr[4:0];
    if (full_addr[6:0] < `BDM_SFR_LIMIT)
    begin
      dec.region = BDM_REGION_SFR; // [RULE_10]
    end
    else if (full_addr >= `BDM_B0_GPR_LO && full_addr <= `BDM_B0_GPR_HI)
    begin
      dec.region = BDM_REGION_GPR; // [RULE_07]
      dec.gpr_index = full_addr[6:0] - `BDM_SFR_LIMIT;
    end
    else if (full_addr >= `BDM_B1_GPR_LO && full_addr <= `BDM_B1_GPR_HI)
    begin
      dec.region = BDM_REGION_GPR; // [RULE_07]
      dec.gpr_index = `BDM_B1_GPR_BASE_IDX + {2'h0, full_addr[4:0]};
    end
    else if (full_addr >= `BDM_B1_ALIAS_LO)
    begin
      dec.region = BDM_REGION_GPR; // [RULE_08]
      dec.gpr_index = `BDM_ALIAS_BASE_IDX + {3'h0, full_addr[3:0]};
    end
  end
endmodule // bdm_addr_decoder

// [bdm_storage.sv]
`timescale 1ns/1ps
`include "bdm_defines.svh"
module bdm_storage
  import bdm_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [6:0] raddr,
  output logic [7:0] rdata
);
  // ==========================================
  // Static array, no reset, no refresh
  logic [7:0] mem [0:`BDM_GPR_DEPTH-1]; // [RULE_03]

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule // bdm_storage

// [bdm_data_memory.sv]
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "bdm_defines.svh"
module bdm_data_memory
  import bdm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input bdm_req_type req,
  input wire logic pc_step,
  input wire logic flags_we,
  input wire logic [2:0] flags_in,
  input wire logic [1:0] power_flags,
  output logic [7:0] rd_data_r,
  output logic [7:0] pc_low_r,
  output logic [7:0] status_r,
  output logic [7:0] pointer_r,
  output logic [4:0] pc_high_latch_r
);
  // ==========================================
  // Helper functions
  function automatic logic [7:0] bdm_direct_addr(input logic bank, input logic [6:0] ofs);
    bdm_direct_addr = {bank, ofs};
  endfunction

  function automatic logic bdm_is_offset(input bdm_decode_type d, input logic [4:0] ofs);
    bdm_is_offset = (d.region == BDM_REGION_SFR) && (d.sfr_offset == ofs);
  endfunction

  function automatic logic bdm_is_indirect(input logic [6:0] a);
    bdm_is_indirect = (a == {2'h0, `BDM_OFS_INDIRECT_DATA});
  endfunction

  function automatic logic [7:0] bdm_status_write(input logic [7:0] cur, input logic [7:0] wd);
    bdm_status_write = (cur & ~`BDM_ST_WRITE_MASK) | (wd & `BDM_ST_WRITE_MASK);
  endfunction

  function automatic logic [7:0] bdm_status_flags(input logic [7:0] cur, input logic [2:0] f);
    bdm_status_flags = (cur & ~`BDM_ST_FLAG_MASK) | {5'h00, f};
  endfunction

  // ==========================================
  // Effective address
  logic indirect;
  logic [7:0] eff_addr;
  bdm_decode_type dec;

  always_comb
  begin
    indirect = bdm_is_indirect(req.addr);
    if (indirect)
    begin
      eff_addr = pointer_r; // [RULE_04]
    end
    else
    begin
      eff_addr = bdm_direct_addr(status_r[`BDM_ST_BANK_SELECT], req.addr); // [RULE_01]
    end
  end

  bdm_addr_decoder u_decoder (
    .full_addr(eff_addr),
    .dec(dec)
  );

  // ==========================================
  // Decoded targets
  logic hit_pc_low;
  logic hit_status;
  logic hit_pointer;
  logic hit_pc_high_latch;
  logic hit_gpr;

  always_comb
  begin
    hit_pc_low = bdm_is_offset(dec, `BDM_OFS_PC_LOW);
    hit_status = bdm_is_offset(dec, `BDM_OFS_STATUS);
    hit_pointer = bdm_is_offset(dec, `BDM_OFS_POINTER);
    hit_pc_high_latch = bdm_is_offset(dec, `BDM_OFS_PC_HIGH_LATCH);
    hit_gpr = (dec.region == BDM_REGION_GPR);
  end

  // ==========================================
  // Write strobes, only to decoded targets
  logic wr_pc_low;
  logic wr_status;
  logic wr_pointer;
  logic wr_pc_high_latch;

  always_comb
  begin
    wr_pc_low = req.we && hit_pc_low;
    wr_status = req.we && hit_status;
    wr_pointer = req.we && hit_pointer;
    wr_pc_high_latch = req.we && hit_pc_high_latch; // [RULE_11]
  end

  // ==========================================
  // General storage
  logic gpr_we;
  logic [7:0] gpr_rdata;

  always_comb
  begin
    gpr_we = req.we && hit_gpr; // [RULE_11]
  end

  bdm_storage u_storage (
    .clk(clk),
    .we(gpr_we),
    .waddr(dec.gpr_index),
    .wdata(req.wdata),
    .raddr(dec.gpr_index),
    .rdata(gpr_rdata)
  );

  // ==========================================
  // Program counter low byte
  logic [7:0] pc_low_nxt;

  always_comb
  begin
    pc_low_nxt = pc_low_r;
    if (wr_pc_low)
    begin
      pc_low_nxt = req.wdata;
    end
    else if (pc_step)
    begin
      pc_low_nxt = pc_low_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_low_r <= `BDM_RST_PC_LOW; // [RULE_06]
    end
    else
    begin
      pc_low_r <= pc_low_nxt; // [RULE_05]
    end
  end

  // ==========================================
  // Status flags
  logic [7:0] status_nxt;
  logic [7:0] status_wr;

  always_comb
  begin
    status_wr = status_r;
    if (flags_we)
    begin
      status_wr = bdm_status_flags(status_r, flags_in);
    end
    if (wr_status)
    begin
      status_wr = bdm_status_write(status_r, req.wdata);
    end
    status_nxt = status_wr;
    status_nxt[`BDM_ST_TIMEOUT] = power_flags[1];
    status_nxt[`BDM_ST_POWERDOWN] = power_flags[0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_r <= `BDM_RST_STATUS;
    end
    else
    begin
      status_r <= status_nxt; // [RULE_05]
    end
  end

  // ==========================================
  // Indirect pointer and high latch
  logic [7:0] pointer_nxt;
  logic [4:0] pc_high_latch_nxt;

  always_comb
  begin
    pointer_nxt = pointer_r;
    pc_high_latch_nxt = pc_high_latch_r;
    if (wr_pointer)
    begin
      pointer_nxt = req.wdata;
    end
    if (wr_pc_high_latch)
    begin
      pc_high_latch_nxt = req.wdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pointer_r <= `BDM_RST_POINTER;
      pc_high_latch_r <= `BDM_RST_PC_HIGH_LATCH;
    end
    else
    begin
      pointer_r <= pointer_nxt; // [RULE_05]
      pc_high_latch_r <= pc_high_latch_nxt;
    end
  end

  // ==========================================
  // Read data, one cycle after the strobe
  logic [7:0] rd_data_nxt;

  always_comb
  begin
    rd_data_nxt = `BDM_RST_READ; // [RULE_09]
    if (req.re)
    begin
      if (hit_gpr)
      begin
        rd_data_nxt = gpr_rdata;
      end
      else if (hit_pc_low)
      begin
        rd_data_nxt = pc_low_r; // [RULE_06]
      end
      else if (hit_status)
      begin
        rd_data_nxt = status_r;
      end
      else if (hit_pointer)
      begin
        rd_data_nxt = pointer_r;
      end
      else if (hit_pc_high_latch)
      begin
        rd_data_nxt = {3'h0, pc_high_latch_r};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data_r <= `BDM_RST_READ;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end
endmodule // bdm_data_memory

// [bdm_data_memory_assertions.sv]
`timescale 1ns/1ps
module bdm_data_memory_assertions
  import bdm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input bdm_req_type req,
  input wire logic pc_step,
  input wire logic flags_we,
  input wire logic [2:0] flags_in,
  input wire logic [1:0] power_flags,
  input wire logic [7:0] rd_data_r,
  input wire logic [7:0] pc_low_r,
  input wire logic [7:0] status_r,
  input wire logic [7:0] pointer_r,
  input wire logic [4:0] pc_high_latch_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ========
  // Port checks
  a_read_idle: assert property (!req.re |=> rd_data_r == 8'h00) else $error("read data not idle");
  a_status_read: assert property (req.re && req.addr == 7'h03 |=> rd_data_r == $past(status_r))
    else $error("status read wrong");
  a_pcl_read: assert property (req.re && req.addr == 7'h02 |=> rd_data_r == $past(pc_low_r))
    else $error("pc low read wrong");
  a_pointer_load: assert property (req.we && req.addr == 7'h04 |=> pointer_r == $past(req.wdata))
    else $error("pointer not loaded");
  a_bank_load: assert property (req.we && req.addr == 7'h03 |=> status_r[5] == $past(req.wdata[5]))
    else $error("bank bit not loaded");
  a_pc_step: assert property (pc_step && !(req.we && req.addr == 7'h02) |=> pc_low_r == $past(pc_low_r) + 8'h01)
    else $error("pc low not stepped");
  a_power_track: assert property ($past(rst_b) |-> status_r[4:3] == $past(power_flags))
    else $error("power flags not tracked");
  a_empty_read: assert property (req.re && req.addr inside {7'h01, 7'h05} |=> rd_data_r == 8'h00)
    else $error("empty place read nonzero");
  a_write_drop: assert property (req.we && req.addr == 7'h01 |=> $stable(pointer_r) && $stable(pc_high_latch_r))
    else $error("dropped write changed state");
  a_flags_load: assert property (flags_we && !req.we |=> status_r[2:0] == $past(flags_in))
    else $error("flags not loaded");
  c_back_reads: cover property (req.re ##1 req.re);
  c_flags: cover property (flags_we);
  c_indirect: cover property (req.we && req.addr == 7'h00);
  c_steps: cover property (pc_step [*3]);
endmodule // bdm_data_memory_assertions

bind bdm_data_memory bdm_data_memory_assertions chk (.clk, .rst_b, .req, .pc_step, .flags_we, .flags_in,
  .power_flags, .rd_data_r, .pc_low_r, .status_r, .pointer_r, .pc_high_latch_r);

// [bdm_core_model.sv]
`timescale 1ns/1ps
module bdm_core_model
  import bdm_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rd_data_r,
  output bdm_req_type req,
  output logic pc_step,
  output logic flags_we,
  output logic [2:0] flags_in,
  output logic [1:0] power_flags
);
  initial
  begin
    req = '0;
    pc_step = 1'b0;
    flags_we = 1'b0;
    flags_in = 3'h0;
    power_flags = 2'h3;
  end
  // ========
  // Operand cycles
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, (a == 7'h03) ? (d & 8'h3F) : d, 1'b1, 1'b0};
    @(posedge clk);
    req.we <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.re <= 1'b0;
    #1 v = rd_data_r;
  endtask
  task automatic step(input int n);
    @(posedge clk);
    pc_step <= 1'b1;
    repeat (n) @(posedge clk);
    pc_step <= 1'b0;
  endtask
  task automatic flags(input logic [2:0] f);
    @(posedge clk);
    flags_in <= f;
    flags_we <= 1'b1;
    @(posedge clk);
    flags_we <= 1'b0;
  endtask
  task automatic power(input logic [1:0] p);
    @(posedge clk);
    power_flags <= p;
  endtask
endmodule // bdm_core_model

// [test_banked_data_memory_decoder.sv]
`timescale 1ns/1ps
module test_banked_data_memory_decoder
  import bdm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  bdm_req_type req;
  logic pc_step;
  logic flags_we;
  logic [2:0] flags_in;
  logic [1:0] power_flags;
  logic [7:0] rd_data_r, pc_low_r, status_r, pointer_r, v;
  logic [4:0] pc_high_latch_r;
  int miscompares = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  bdm_data_memory dut (.clk, .rst_b, .req, .pc_step, .flags_we, .flags_in, .power_flags, .rd_data_r,
    .pc_low_r, .status_r, .pointer_r, .pc_high_latch_r);
  bdm_core_model m (.clk, .rd_data_r, .req, .pc_step, .flags_we, .flags_in, .power_flags);
  // ========
  // Checking
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] exp);
    m.rd(a, v);
    check("read data", v, exp);
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ========
  // Scenarios
  task automatic t_banks();
    check("status", status_r, 8'h18);
    rc(7'h02, 8'h00);
    m.wr(7'h20, 8'h5A);
    m.wr(7'h03, 8'h20);
    m.wr(7'h20, 8'hC3);
    m.wr(7'h3F, 8'h77);
    rc(7'h20, 8'hC3);
    rc(7'h3F, 8'h77);
    m.wr(7'h03, 8'h00);
    rc(7'h20, 8'h5A);
  endtask
  task automatic t_alias();
    m.wr(7'h75, 8'h3C);
    m.wr(7'h03, 8'h20);
    rc(7'h75, 8'h3C);
    m.wr(7'h7F, 8'h99);
    m.wr(7'h03, 8'h00);
    rc(7'h7F, 8'h99);
  endtask
  task automatic t_indirect();
    m.wr(7'h04, 8'hA5);
    m.wr(7'h00, 8'h11);
    m.wr(7'h03, 8'h20);
    rc(7'h25, 8'h11);
    m.wr(7'h04, 8'h20);
    rc(7'h00, 8'h5A);
    m.wr(7'h04, 8'h8A);
    m.wr(7'h00, 8'h15);
    rc(7'h0A, 8'h15);
    m.wr(7'h04, 8'h00);
    rc(7'h00, 8'h00);
  endtask
  task automatic t_empty();
    m.wr(7'h40, 8'hFF);
    rc(7'h40, 8'h00);
    m.wr(7'h01, 8'hFF);
    rc(7'h01, 8'h00);
    rc(7'h3F, 8'h77);
    check("pointer", pointer_r, 8'h00);
  endtask
  task automatic t_special();
    m.step(3);
    rc(7'h02, 8'h03);
    m.wr(7'h0A, 8'hFF);
    rc(7'h0A, 8'h1F);
    check("pc high latch", {3'h0, pc_high_latch_r}, 8'h1F);
    m.wr(7'h02, 8'hFE);
    m.step(1);
    rc(7'h02, 8'hFF);
    check("pc low", pc_low_r, 8'hFF);
  endtask
  task automatic t_flags();
    m.wr(7'h03, 8'h00);
    m.flags(3'h5);
    #1 check("status", status_r, 8'h1D);
    m.power(2'h1);
    rc(7'h03, 8'h0D);
    m.wr(7'h03, 8'hDF);
    rc(7'h03, 8'h0F);
    m.power(2'h3);
  endtask
  task automatic t_reset();
    m.step(2);
    @(posedge clk);
    rst_b <= 1'b0;
    #1 check("pc low", pc_low_r, 8'h00);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    check("pc high latch", {3'h0, pc_high_latch_r}, 8'h00);
    check("status", status_r, 8'h18);
    rc(7'h02, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_banks();
    t_alias();
    t_indirect();
    t_empty();
    t_special();
    t_flags();
    t_reset();
    complete_run();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule // test_banked_data_memory_decoder
